// File: rtl/waveform_capture_serial_tx.sv
// transmit-only serial master streaming sign-extended waveform and power words
// assumes sample_tick is a one-cycle 8 kHz strobe and all inputs share ref_clk
`timescale 1ns/1ps
`default_nettype none
module waveform_capture_serial_tx
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration register port
    input wire logic cfg_wr_en,
    input wire logic [7:0] cfg_wr_data,
    output logic [7:0] cfg_rd_data,
    // port enable and sampling strobe
    input wire logic port_enable,
    input wire logic sample_tick,
    // source words, slot 0 first
    input wire logic [15:0][23:0] sample_words,
    // status
    output logic busy,
    // serial pins
    output logic capture_select_pin,
    output logic capture_data_pin,
    output logic capture_clock_pin
);

    // reset release through two flip-flops
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // configuration register
    logic [7:0] cfg_q, cfg_d;
    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_wr_en)
            cfg_d = cfg_wr_data; // bits 7:6 stored and read back, never used
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= capture_port_pkg::CFG_RESET;
        else
            cfg_q <= cfg_d;
    end
    assign cfg_rd_data = cfg_q;

    logic [1:0] word_set;
    logic gap_on, byte_pkg, slow_clk, sel_pol;
    assign word_set = cfg_q[capture_port_pkg::CFG_WORD_SET_LSB +: 2];
    assign gap_on = cfg_q[capture_port_pkg::CFG_PACKAGE_GAP_BIT];
    assign byte_pkg = cfg_q[capture_port_pkg::CFG_PACKAGE_SIZE_BIT];
    assign slow_clk = cfg_q[capture_port_pkg::CFG_CLOCK_RATE_BIT];
    assign sel_pol = cfg_q[capture_port_pkg::CFG_SELECT_POLARITY_BIT];

    // two-entry word buffer between fetch and serializer
    logic [32:0] fifo_mem_q [2];
    logic [32:0] fifo_mem_d [2];
    logic fifo_wp_q, fifo_wp_d, fifo_rp_q, fifo_rp_d;
    logic [1:0] fifo_cnt_q, fifo_cnt_d;
    logic push, pop, fifo_ready, fifo_valid;
    logic [32:0] push_word;
    assign fifo_ready = (fifo_cnt_q != 2'h2);
    assign fifo_valid = (fifo_cnt_q != 2'h0);

    // transfer control and word fetch
    capture_port_pkg::fetch_state_t fetch_q, fetch_d;
    logic [15:0][23:0] snap_q, snap_d;
    logic [3:0] word_idx_q, word_idx_d;
    logic [4:0] words_left_q, words_left_d;
    logic active_q, active_d;
    logic start_go, done_q, done_d;
    logic [23:0] src;

    assign start_go = (fetch_q == capture_port_pkg::F_IDLE) && sample_tick && port_enable;
    assign src = snap_q[word_idx_q];
    assign push = (fetch_q == capture_port_pkg::F_FEED) && fifo_ready; // stalls on full buffer
    assign push_word = {(words_left_q == 5'h01), {8{src[23]}}, src}; // sign extension

    always_comb
    begin
        fetch_d = fetch_q;
        snap_d = snap_q;
        word_idx_d = word_idx_q;
        words_left_d = words_left_q;
        active_d = active_q;
        unique case (fetch_q)
            capture_port_pkg::F_IDLE:
            begin
                // a tick that lands during a transfer is skipped
                if (start_go)
                begin
                    snap_d = sample_words; // one sampling cycle per transfer
                    active_d = 1'b1;
                    fetch_d = capture_port_pkg::F_FEED;
                    unique case (word_set)
                        capture_port_pkg::SET_WAVEFORM:
                        begin
                            word_idx_d = capture_port_pkg::FIRST_WAVEFORM;
                            words_left_d = capture_port_pkg::COUNT_WAVEFORM;
                        end
                        capture_port_pkg::SET_POWER:
                        begin
                            word_idx_d = capture_port_pkg::FIRST_POWER;
                            words_left_d = capture_port_pkg::COUNT_POWER;
                        end
                        default:
                        begin
                            word_idx_d = capture_port_pkg::FIRST_ALL; // 00 and 11 alike
                            words_left_d = capture_port_pkg::COUNT_ALL;
                        end
                    endcase
                end
            end
            capture_port_pkg::F_FEED:
            begin
                if (push)
                begin
                    word_idx_d = word_idx_q + 4'h1; // slot order gives the wire order
                    words_left_d = words_left_q - 5'h01;
                    if (words_left_q == 5'h01)
                        fetch_d = capture_port_pkg::F_WAIT;
                end
            end
            capture_port_pkg::F_WAIT:
            begin
                if (done_q)
                begin
                    active_d = 1'b0;
                    fetch_d = capture_port_pkg::F_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_q <= capture_port_pkg::F_IDLE;
            snap_q <= '0;
            word_idx_q <= 4'h0;
            words_left_q <= 5'h00;
            active_q <= 1'b0;
        end
        else
        begin
            fetch_q <= fetch_d;
            snap_q <= snap_d;
            word_idx_q <= word_idx_d;
            words_left_q <= words_left_d;
            active_q <= active_d;
        end
    end

    // buffer pointers and storage
    always_comb
    begin
        fifo_mem_d = fifo_mem_q;
        fifo_wp_d = fifo_wp_q;
        fifo_rp_d = fifo_rp_q;
        fifo_cnt_d = fifo_cnt_q;
        if (push)
        begin
            fifo_mem_d[fifo_wp_q] = push_word;
            fifo_wp_d = ~fifo_wp_q;
        end
        if (pop)
            fifo_rp_d = ~fifo_rp_q;
        if (push && !pop)
            fifo_cnt_d = fifo_cnt_q + 2'h1;
        else if (pop && !push)
            fifo_cnt_d = fifo_cnt_q - 2'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_mem_q[0] <= 33'h0;
            fifo_mem_q[1] <= 33'h0;
            fifo_wp_q <= 1'b0;
            fifo_rp_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end
        else
        begin
            fifo_mem_q <= fifo_mem_d;
            fifo_wp_q <= fifo_wp_d;
            fifo_rp_q <= fifo_rp_d;
            fifo_cnt_q <= fifo_cnt_d;
        end
    end

    // serializer: falling edge at tick 0, rising edge at mid period
    capture_port_pkg::ser_state_t ser_q, ser_d;
    logic [31:0] shreg_q, shreg_d;
    logic last_q, last_d;
    logic [4:0] bit_cnt_q, bit_cnt_d;
    logic [5:0] tick_q, tick_d;
    logic [2:0] gap_left_q, gap_left_d;
    logic clk_q, clk_d, data_q, data_d, sel_q, sel_d;
    logic [5:0] last_tick, rise_tick;
    logic word_end, pkg_end, next_bit;
    logic [32:0] head;

    assign last_tick = slow_clk ? capture_port_pkg::SLOW_LAST_TICK
                                : capture_port_pkg::FAST_LAST_TICK;
    assign rise_tick = slow_clk ? capture_port_pkg::SLOW_RISE_TICK
                                : capture_port_pkg::FAST_RISE_TICK;
    assign word_end = (bit_cnt_q == capture_port_pkg::LAST_BIT);
    assign pkg_end = word_end || (byte_pkg && bit_cnt_q[2:0] == capture_port_pkg::BYTE_LAST_BIT);
    assign head = fifo_mem_q[fifo_rp_q];

    always_comb
    begin
        ser_d = ser_q;
        shreg_d = shreg_q;
        last_d = last_q;
        bit_cnt_d = bit_cnt_q;
        tick_d = tick_q;
        gap_left_d = gap_left_q;
        clk_d = clk_q;
        data_d = data_q;
        done_d = 1'b0;
        pop = 1'b0;
        next_bit = 1'b0;
        unique case (ser_q)
            capture_port_pkg::S_IDLE:
                pop = fifo_valid;
            capture_port_pkg::S_SHIFT:
            begin
                if (tick_q == last_tick)
                begin
                    if (word_end && last_q)
                    begin
                        ser_d = capture_port_pkg::S_IDLE;
                        done_d = 1'b1;
                    end
                    else if (pkg_end && gap_on) // gap only with its bit set
                    begin
                        ser_d = capture_port_pkg::S_GAP;
                        gap_left_d = capture_port_pkg::GAP_PERIODS;
                        tick_d = 6'h00;
                    end
                    else if (word_end)
                    begin
                        pop = fifo_valid; // back-to-back words without a pause
                        if (!fifo_valid)
                            ser_d = capture_port_pkg::S_IDLE;
                    end
                    else
                        next_bit = 1'b1;
                end
                else
                begin
                    tick_d = tick_q + 6'h01;
                    if (tick_q == rise_tick)
                        clk_d = 1'b1; // receiver samples on this rising edge
                end
            end
            capture_port_pkg::S_GAP:
            begin
                // clock held high for the whole gap
                if (tick_q != last_tick)
                    tick_d = tick_q + 6'h01;
                else if (gap_left_q != 3'h1)
                begin
                    gap_left_d = gap_left_q - 3'h1;
                    tick_d = 6'h00;
                end
                else if (word_end)
                    pop = fifo_valid;
                else
                    next_bit = 1'b1;
            end
        endcase
        if (pop)
        begin
            shreg_d = head[31:0];
            last_d = head[32];
            bit_cnt_d = 5'h00;
            tick_d = 6'h00;
            clk_d = 1'b0;
            data_d = head[31]; // msb leaves first
            ser_d = capture_port_pkg::S_SHIFT;
        end
        if (next_bit)
        begin
            shreg_d = {shreg_q[30:0], 1'b0};
            data_d = shreg_q[30]; // new bit on the falling edge
            bit_cnt_d = bit_cnt_q + 5'h01;
            tick_d = 6'h00;
            clk_d = 1'b0;
            ser_d = capture_port_pkg::S_SHIFT;
        end
        sel_d = sel_pol ? active_q : !active_q;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ser_q <= capture_port_pkg::S_IDLE;
            shreg_q <= 32'h0;
            last_q <= 1'b0;
            bit_cnt_q <= 5'h00;
            tick_q <= 6'h00;
            gap_left_q <= 3'h0;
            clk_q <= 1'b1;
            data_q <= 1'b1;
            sel_q <= 1'b1;
            done_q <= 1'b0;
        end
        else
        begin
            ser_q <= ser_d;
            shreg_q <= shreg_d;
            last_q <= last_d;
            bit_cnt_q <= bit_cnt_d;
            tick_q <= tick_d;
            gap_left_q <= gap_left_d;
            clk_q <= clk_d;
            data_q <= data_d;
            sel_q <= sel_d;
            done_q <= done_d;
        end
    end

    assign capture_select_pin = sel_q;
    assign capture_data_pin = data_q;
    assign capture_clock_pin = clk_q;
    assign busy = active_q;

    // checks on the transmitter's own behaviour
    a_full_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start_go && (word_set == 2'h0 || word_set == 2'h3))
        |=> (words_left_q == 5'h10 && word_idx_q == 4'h0))
        else $error("full word set not loaded");
    a_wave_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start_go && word_set == 2'h1) |=> (words_left_q == 5'h07 && word_idx_q == 4'h0))
        else $error("waveform word set not loaded");
    a_power_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start_go && word_set == 2'h2) |=> (words_left_q == 5'h09 && word_idx_q == 4'h7))
        else $error("power word set not loaded");
    a_slot_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (push && words_left_q != 5'h01) |=> (word_idx_q == $past(word_idx_q) + 4'h1))
        else $error("words left out of slot order");
    a_select_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ser_q == capture_port_pkg::S_SHIFT && !sel_pol && $stable(sel_pol))
        |-> !capture_select_pin)
        else $error("select not low while shifting");
    a_select_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ser_q == capture_port_pkg::S_SHIFT && sel_pol && $stable(sel_pol))
        |-> capture_select_pin)
        else $error("select not high while shifting");
    a_no_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!gap_on && $stable(gap_on)) |=> ser_q != capture_port_pkg::S_GAP)
        else $error("gap inserted with gaps off");
    a_gap_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ser_q == capture_port_pkg::S_SHIFT) ##1 (ser_q == capture_port_pkg::S_GAP)
        |-> (gap_left_q == 3'h7 && tick_q == 6'h00 && capture_clock_pin))
        else $error("gap not seven periods");
    a_low_phase: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ($fell(capture_clock_pin) && !slow_clk) |-> (!capture_clock_pin)[*8])
        else $error("serial clock low phase too short");
    a_snapshot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start_go |=> (snap_q == $past(sample_words)))
        else $error("sources not latched at start");
    a_busy_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sample_tick && active_q) |=> $stable(snap_q))
        else $error("snapshot changed during a transfer");

endmodule
`default_nettype wire

// File: rtl/capture_port_pkg.sv
// capture port package: register layout, word sets, timing constants and state codes
// assumes a 200 MHz system clock feeding the serial transmitter
package capture_port_pkg;

    // capture_port_config field positions and reset value
    localparam int CFG_CLOCK_RATE_BIT = 0;
    localparam int CFG_PACKAGE_SIZE_BIT = 1;
    localparam int CFG_PACKAGE_GAP_BIT = 2;
    localparam int CFG_WORD_SET_LSB = 3;
    localparam int CFG_SELECT_POLARITY_BIT = 5;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // word_set_select codes
    localparam logic [1:0] SET_ALL = 2'h0;
    localparam logic [1:0] SET_WAVEFORM = 2'h1;
    localparam logic [1:0] SET_POWER = 2'h2;
    localparam logic [1:0] SET_RESERVED = 2'h3;

    // source slot order: ia va ib vb ic vc in, then apparent, active, reactive a/b/c
    localparam logic [3:0] FIRST_ALL = 4'h0;
    localparam logic [4:0] COUNT_ALL = 5'h10;
    localparam logic [3:0] FIRST_WAVEFORM = 4'h0;
    localparam logic [4:0] COUNT_WAVEFORM = 5'h07;
    localparam logic [3:0] FIRST_POWER = 4'h7;
    localparam logic [4:0] COUNT_POWER = 5'h09;

    // serial format
    localparam int SOURCE_BITS = 24;
    localparam int WORD_BITS = 32;
    localparam logic [4:0] LAST_BIT = 5'h1f;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [2:0] GAP_PERIODS = 3'h7;

    // serial clock timing derived from the system clock period
    localparam int CLK_PERIOD_NS = 5;
    localparam int FAST_PERIOD_NS = 125;
    localparam int SLOW_PERIOD_NS = 250;
    localparam logic [5:0] FAST_LAST_TICK = 6'(FAST_PERIOD_NS / CLK_PERIOD_NS - 1);
    localparam logic [5:0] SLOW_LAST_TICK = 6'(SLOW_PERIOD_NS / CLK_PERIOD_NS - 1);
    localparam logic [5:0] FAST_RISE_TICK = 6'(FAST_PERIOD_NS / CLK_PERIOD_NS / 2 - 1);
    localparam logic [5:0] SLOW_RISE_TICK = 6'(SLOW_PERIOD_NS / CLK_PERIOD_NS / 2 - 1);

    // transfer control and serializer states
    typedef enum logic [2:0] {
        F_IDLE = 3'b001,
        F_FEED = 3'b010,
        F_WAIT = 3'b100
    } fetch_state_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_SHIFT = 3'b010,
        S_GAP = 3'b100
    } ser_state_t;

endpackage

// File: verification/capture_receiver_model.sv
// receiving serial slave model that collects 32-bit words from the capture port pins
// assumes it oversamples the pins with the transmitter's own system clock
`timescale 1ns/1ps
`default_nettype none
module capture_receiver_model
(
    // oversampling clock and bench control
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic pol,
    // serial pins from the transmitter
    input wire logic sel,
    input wire logic sdata,
    input wire logic sclk
);
    logic [31:0] words[$];
    logic [31:0] sr = 32'h0;
    logic clk_q = 1'b1;
    logic dat_q = 1'b1;
    int nbits = 0;
    int sel_cycles = 0;
    int glitches = 0;

    // shift in on sampled rising clock edges, only inside an active select window
    always @(posedge ref_clk)
    begin
        if (clr)
        begin
            words.delete();
            nbits = 0;
            sel_cycles = 0;
        end
        else if (sel === pol)
        begin
            sel_cycles++;
            // idle gaps simply bring no rising edge, so packages may pause freely
            if (!clk_q && sclk)
            begin
                sr = {sr[30:0], sdata};
                nbits++;
                if (nbits == 32)
                begin
                    words.push_back(sr);
                    nbits = 0;
                end
            end
            // data must stay put while the clock is high inside a word
            if (clk_q && sclk && nbits != 0 && sdata !== dat_q)
                glitches++;
        end
        else
            nbits = 0;
        clk_q = sclk;
        dat_q = sdata;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the waveform capture serial transmitter
// assumes the receiver model in its own file and a 200 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [7:0] cfg; int first; int cnt; int dur;} row_t;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cfg_wr_en = 1'b0;
    logic [7:0] cfg_wr_data = 8'h00;
    logic [7:0] cfg_rd_data;
    logic port_enable = 1'b1;
    logic sample_tick = 1'b0;
    logic [15:0][23:0] sample_words;
    logic [15:0][23:0] words_in;
    logic busy;
    logic capture_select_pin;
    logic capture_data_pin;
    logic capture_clock_pin;
    logic pol = 1'b0;
    logic clr = 1'b0;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // config, first slot, word count, duration in system clock cycles
    row_t rows[6] = '{'{8'h00, 0, 16, 12800}, '{8'h08, 0, 7, 5600}, '{8'h10, 7, 9, 7200},
        '{8'h1c, 0, 16, 15425}, '{8'hee, 0, 7, 10325}, '{8'h0b, 0, 7, 11200}};

    waveform_capture_serial_tx i_waveform_capture_serial_tx (.ref_clk(ref_clk), .rstn(rstn),
        .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
        .port_enable(port_enable), .sample_tick(sample_tick), .sample_words(sample_words),
        .busy(busy), .capture_select_pin(capture_select_pin),
        .capture_data_pin(capture_data_pin), .capture_clock_pin(capture_clock_pin));

    capture_receiver_model i_capture_receiver_model (.ref_clk(ref_clk), .clr(clr), .pol(pol),
        .sel(capture_select_pin), .sdata(capture_data_pin), .sclk(capture_clock_pin));

    // 200 MHz system clock
    always #2.5 ref_clk = ~ref_clk;

    // hang guard sized for about 76k cycles of traffic
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic end_sim();
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // one-cycle write, then model cleared once the new select level has landed
    task automatic start(input logic [7:0] v);
        begin
            @(posedge ref_clk);
            cfg_wr_en <= 1'b1;
            cfg_wr_data <= v;
            @(posedge ref_clk);
            cfg_wr_en <= 1'b0;
            pol <= v[5];
            clr <= 1'b1;
            repeat (2) @(posedge ref_clk);
            clr <= 1'b0;
            sample_tick <= 1'b1;
            @(posedge ref_clk);
            sample_tick <= 1'b0;
        end
    endtask

    task automatic wait_idle();
        int n;
        begin
            // busy only rises after the tick edge has been taken
            repeat (2) @(posedge ref_clk);
            for (n = 0; n < 20000 && busy !== 1'b0; n++)
                @(posedge ref_clk);
            repeat (8) @(posedge ref_clk);
        end
    endtask

    // received words against sign-extended source slots
    task automatic chk_words(input int first, input int cnt);
        int k;
        logic [23:0] w;
        begin
            check(32'(i_capture_receiver_model.words.size()), 32'(cnt));
            for (k = 0; k < cnt && k < i_capture_receiver_model.words.size(); k++)
            begin
                w = words_in[first + k];
                check(i_capture_receiver_model.words[k], {{8{w[23]}}, w});
            end
        end
    endtask

    initial
    begin
        // source slots with both signs
        for (int i = 0; i < 16; i++)
            words_in[i] = {i[0], 23'(i * 32'h2bd5e1 + 32'h1234)};
        sample_words = words_in;
        repeat (8) @(posedge ref_clk);
        // pins while held in reset
        check({29'h0, capture_select_pin, capture_data_pin, capture_clock_pin}, 32'h7);
        check(32'(busy), 32'h0);
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(cfg_rd_data), 32'(capture_port_pkg::CFG_RESET));
        check(32'(capture_select_pin), 32'h1);
        // table of configurations
        foreach (rows[r])
        begin
            start(rows[r].cfg);
            wait_idle();
            chk_words(rows[r].first, rows[r].cnt);
            check(32'(cfg_rd_data), 32'(rows[r].cfg));
            check(32'(i_capture_receiver_model.sel_cycles >= rows[r].dur &&
                i_capture_receiver_model.sel_cycles <= rows[r].dur + 10), 32'h1);
            check(32'(capture_select_pin), 32'(!rows[r].cfg[5]));
        end
        // tick while busy is skipped and sources change mid-transfer
        start(8'h08);
        repeat (1000) @(posedge ref_clk);
        sample_words <= ~words_in;
        sample_tick <= 1'b1;
        @(posedge ref_clk);
        sample_tick <= 1'b0;
        wait_idle();
        chk_words(0, 7);
        repeat (50) @(posedge ref_clk);
        check(32'(busy), 32'h0);
        sample_words <= words_in;
        // no transfer while the port is disabled
        port_enable <= 1'b0;
        sample_tick <= 1'b1;
        @(posedge ref_clk);
        sample_tick <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check(32'(busy), 32'h0);
        // reset in mid-transfer returns pins, status and register to idle
        port_enable <= 1'b1;
        start(8'h08);
        repeat (500) @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({29'h0, capture_select_pin, capture_data_pin, capture_clock_pin}, 32'h7);
        check(32'(busy), 32'h0);
        check(32'(cfg_rd_data), 32'(capture_port_pkg::CFG_RESET));
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // a clean transfer after the second release
        start(8'h10);
        wait_idle();
        chk_words(7, 9);
        check(32'(i_capture_receiver_model.glitches), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
